/* pkg/csrm_pkg.sv */
// constants for the current scale and ramp mode register bank
// assumes a 32-bit apb slave with one aligned word per register
`default_nettype none
package csrm_pkg;
    // register indices as printed; byte address is four times the index
    localparam logic [7:0] PHASE_SCALE_IDX = 8'h06;
    localparam logic [7:0] RAMP_MODE_IDX = 8'h07;
    localparam logic [7:0] BANK_STATUS_IDX = 8'h20;
    localparam logic [9:0] PHASE_SCALE_ADDR = {PHASE_SCALE_IDX, 2'b00};
    localparam logic [9:0] RAMP_MODE_ADDR = {RAMP_MODE_IDX, 2'b00};
    localparam logic [9:0] BANK_STATUS_ADDR = {BANK_STATUS_IDX, 2'b00};
    localparam int ADDR_W = 10;

    // reset values
    localparam logic [31:0] PHASE_SCALE_RST = 32'h0000_0000;
    localparam logic [31:0] RAMP_MODE_RST = 32'h0000_0000;

    // scale field layout: phase p sits at bits 8p+7:8p
    localparam int SCALE_W = 8;
    localparam int PHASE_CNT = 4;
    localparam int MOTOR_CNT = 2;
    localparam logic [8:0] SCALE_FULL = 9'h100;
    localparam logic [7:0] SCALE_MIN_LEGAL = 8'h20;

    // ramp mode field layout
    localparam int MOTOR0_RAMP_LSB = 0;
    localparam int MOTOR1_RAMP_LSB = 2;
    localparam int RAMP_SEL_W = 2;
    localparam int SYNC_UPDATE_BIT = 8;
    localparam int AXIS_INTERP_BIT = 9;
    localparam logic [31:0] RAMP_MODE_MASK = 32'h0000_030F;

    // status layout (read only)
    localparam int STAT_PEND_BIT = 0;
    localparam int STAT_BAD_LSB = 4;

    typedef enum logic [1:0] {
        CSRM_RAMP_POSITION = 2'b00,
        CSRM_RAMP_VEL_POS = 2'b01,
        CSRM_RAMP_VEL_NEG = 2'b10,
        CSRM_RAMP_HOLD = 2'b11
    } csrm_ramp_t;
endpackage
`default_nettype wire

/* rtl/csrm_mode_dec.sv */
// ramp selection field of one motor decoded into one-hot drive commands
// assumes the ramp generator outside acts on exactly one command at a time
`timescale 1ns/1ps
`default_nettype none
module csrm_mode_dec (
    input wire logic [1:0] sel_i,
    output logic position_o,
    output logic vel_pos_o,
    output logic vel_neg_o,
    output logic hold_o
);
    csrm_pkg::csrm_ramp_t mode;

    always_comb begin
        mode = csrm_pkg::csrm_ramp_t'(sel_i);
        position_o = 1'b0;
        vel_pos_o = 1'b0;
        vel_neg_o = 1'b0;
        hold_o = 1'b0;
        case (mode)
            csrm_pkg::CSRM_RAMP_POSITION: position_o = 1'b1;
            csrm_pkg::CSRM_RAMP_VEL_POS: vel_pos_o = 1'b1;
            csrm_pkg::CSRM_RAMP_VEL_NEG: vel_neg_o = 1'b1;
            csrm_pkg::CSRM_RAMP_HOLD: hold_o = 1'b1;
            default: position_o = 1'b1;
        endcase
    end
endmodule
`default_nettype wire

/* rtl/csrm_scale_dec.sv */
// one phase scale factor turned into an effective multiplier out of 256
// assumes the factor comes straight from the bank register
`timescale 1ns/1ps
`default_nettype none
module csrm_scale_dec #(
    parameter int W = 8
) (
    input wire logic [W-1:0] factor_i,
    output logic [W:0] mult_o,
    output logic illegal_o
);
    always_comb begin
        if (factor_i == '0) begin
            mult_o = csrm_pkg::SCALE_FULL;
        end else begin
            mult_o = {1'b0, factor_i};
        end
    end

    // values 1..31 are the host's fault; flagged only, never corrected
    assign illegal_o = (factor_i != '0) && (factor_i < csrm_pkg::SCALE_MIN_LEGAL);
endmodule
`default_nettype wire

/* rtl/csrm_top.sv */
// current scale and ramp mode register bank with apb slave
// assumes apb master in the same clock domain; ramp generators and
// target position registers live outside and act on the outputs
// Function
// - scale register holds four 8-bit phase factors, A, B, C, D from low byte up.
// - a factor of zero means full scale, 256 out of 256.
// - a factor N from 32 to 255 gives N/256 of maximum current.
// - 2-bit ramp select per motor at bits 1:0 and 3:2; 0 is positioning.
// - select 1 runs toward positive peak velocity at peak acceleration.
// - select 2 runs toward negative peak velocity at peak acceleration.
// - select 3 holds velocity; only a stop event changes it.
// - bit 9 picks independent axes or coordinated interpolated ramping.
// - bit 8 set applies both new targets when motor 1 target is written.
//
// Added by the designer: the APB register port.
`timescale 1ns/1ps
`default_nettype none
module csrm_top #(
    parameter int SCALE_W = csrm_pkg::SCALE_W
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [csrm_pkg::ADDR_W-1:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [3:0] pstrb_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic motor0_target_wr_i,
    input wire logic motor1_target_wr_i,
    output logic motor0_target_apply_o,
    output logic motor1_target_apply_o,
    output logic [SCALE_W:0] motor0_phase_a_scale_o,
    output logic [SCALE_W:0] motor0_phase_b_scale_o,
    output logic [SCALE_W:0] motor1_phase_c_scale_o,
    output logic [SCALE_W:0] motor1_phase_d_scale_o,
    output logic [1:0] motor0_ramp_select_o,
    output logic [1:0] motor1_ramp_select_o,
    output logic [3:0] motor0_ramp_cmd_o,
    output logic [3:0] motor1_ramp_cmd_o,
    output logic axis_interp_o,
    output logic sync_update_o
);
    localparam int PW = csrm_pkg::PHASE_CNT * SCALE_W;

    // address decode, shared by read and write paths
    function automatic logic [2:0] sel_reg(input logic [csrm_pkg::ADDR_W-1:0] a);
        logic [2:0] s;
        s = 3'h0;
        if (a == csrm_pkg::PHASE_SCALE_ADDR) begin
            s = 3'h1;
        end else if (a == csrm_pkg::RAMP_MODE_ADDR) begin
            s = 3'h2;
        end else if (a == csrm_pkg::BANK_STATUS_ADDR) begin
            s = 3'h4;
        end
        return s;
    endfunction

    logic [PW-1:0] phase_current_scale_r;
    logic [31:0] ramp_mode_control_r;
    logic pready_r;
    logic pslverr_r;
    logic [31:0] prdata_r;
    logic [31:0] prdata_nxt;
    logic sync_pend_r;
    logic apply0_r;
    logic apply1_r;
    logic [2:0] hit;
    logic access;
    logic wr_fire;
    logic rd_fire;
    logic [PW-1:0] scale_nxt;
    logic [31:0] ramp_nxt;
    logic [csrm_pkg::PHASE_CNT-1:0] bad_scale;
    logic [(SCALE_W+1)*csrm_pkg::PHASE_CNT-1:0] mult;
    logic [(SCALE_W+1)*csrm_pkg::PHASE_CNT-1:0] mult_r;
    logic [3:0] cmd0;
    logic [3:0] cmd1;
    logic [3:0] cmd0_r;
    logic [3:0] cmd1_r;
    logic sync_on;

    assign hit = sel_reg(paddr_i);
    // one wait state: pready rises in the second access cycle, read data is
    // captured with it so every bus output leaves a flip-flop
    assign access = psel_i && penable_i && !pready_r;
    assign wr_fire = psel_i && penable_i && pready_r && pwrite_i && !pslverr_r;
    assign rd_fire = access && !pwrite_i;
    assign sync_on = ramp_mode_control_r[csrm_pkg::SYNC_UPDATE_BIT];

    // byte strobes merge into the current value
    always_comb begin
        scale_nxt = phase_current_scale_r;
        ramp_nxt = ramp_mode_control_r;
        for (int b = 0; b < 4; b++) begin
            if (pstrb_i[b]) begin
                scale_nxt[b*8 +: 8] = pwdata_i[b*8 +: 8];
                ramp_nxt[b*8 +: 8] = pwdata_i[b*8 +: 8];
            end
        end
        ramp_nxt = ramp_nxt & csrm_pkg::RAMP_MODE_MASK;
    end

    // exactly one wait state: ready answers the first access cycle
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pready_r <= 1'b0;
        end else begin
            pready_r <= access;
        end
    end

    // unmapped addresses and writes to the status word are refused
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pslverr_r <= 1'b0;
        end else begin
            pslverr_r <= access && ((hit == 3'h0) || (pwrite_i && hit[2]));
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            phase_current_scale_r <= csrm_pkg::PHASE_SCALE_RST;
        end else if (wr_fire && hit[0]) begin
            phase_current_scale_r <= scale_nxt;
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ramp_mode_control_r <= csrm_pkg::RAMP_MODE_RST;
        end else if (wr_fire && hit[1]) begin
            ramp_mode_control_r <= ramp_nxt;
        end
    end

    always_comb begin
        prdata_nxt = 32'h0000_0000;
        if (hit[0]) begin
            prdata_nxt = phase_current_scale_r;
        end else if (hit[1]) begin
            prdata_nxt = ramp_mode_control_r & csrm_pkg::RAMP_MODE_MASK;
        end else if (hit[2]) begin
            prdata_nxt[csrm_pkg::STAT_PEND_BIT] = sync_pend_r;
            prdata_nxt[csrm_pkg::STAT_BAD_LSB +: csrm_pkg::PHASE_CNT] = bad_scale;
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            prdata_r <= 32'h0000_0000;
        end else if (rd_fire) begin
            prdata_r <= prdata_nxt;
        end else if (!access) begin
            prdata_r <= 32'h0000_0000;
        end
    end

    // per-phase decode of the scale factors
    for (genvar p = 0; p < csrm_pkg::PHASE_CNT; p++) begin : g_phase
        csrm_scale_dec #(
            .W(SCALE_W)
        ) u_scale (
            .factor_i(phase_current_scale_r[p*SCALE_W +: SCALE_W]),
            .mult_o(mult[p*(SCALE_W+1) +: SCALE_W+1]),
            .illegal_o(bad_scale[p])
        );
    end

    csrm_mode_dec u_mode0 (
        .sel_i(ramp_mode_control_r[csrm_pkg::MOTOR0_RAMP_LSB +: csrm_pkg::RAMP_SEL_W]),
        .position_o(cmd0[0]),
        .vel_pos_o(cmd0[1]),
        .vel_neg_o(cmd0[2]),
        .hold_o(cmd0[3])
    );

    csrm_mode_dec u_mode1 (
        .sel_i(ramp_mode_control_r[csrm_pkg::MOTOR1_RAMP_LSB +: csrm_pkg::RAMP_SEL_W]),
        .position_o(cmd1[0]),
        .vel_pos_o(cmd1[1]),
        .vel_neg_o(cmd1[2]),
        .hold_o(cmd1[3])
    );

    // multipliers read zero while in reset; full scale shows one edge after release
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            mult_r <= '0;
        end else begin
            mult_r <= mult;
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cmd0_r <= 4'h1;
        end else begin
            cmd0_r <= cmd0;
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cmd1_r <= 4'h1;
        end else begin
            cmd1_r <= cmd1;
        end
    end

    // synchronized target update: a motor 0 target write waits for the
    // motor 1 write; clearing the mode releases a waiting target at once
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sync_pend_r <= 1'b0;
        end else if (!sync_on || motor1_target_wr_i) begin
            sync_pend_r <= 1'b0;
        end else if (motor0_target_wr_i) begin
            sync_pend_r <= 1'b1;
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            apply0_r <= 1'b0;
        end else if (sync_on) begin
            apply0_r <= motor1_target_wr_i;
        end else begin
            apply0_r <= motor0_target_wr_i || sync_pend_r;
        end
    end

    // motor 1 applies on its own write in either mode
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            apply1_r <= 1'b0;
        end else begin
            apply1_r <= motor1_target_wr_i;
        end
    end

    assign prdata_o = prdata_r;
    assign pready_o = pready_r;
    assign pslverr_o = pslverr_r;
    assign motor0_target_apply_o = apply0_r;
    assign motor1_target_apply_o = apply1_r;
    assign motor0_phase_a_scale_o = mult_r[0*(SCALE_W+1) +: SCALE_W+1];
    assign motor0_phase_b_scale_o = mult_r[1*(SCALE_W+1) +: SCALE_W+1];
    assign motor1_phase_c_scale_o = mult_r[2*(SCALE_W+1) +: SCALE_W+1];
    assign motor1_phase_d_scale_o = mult_r[3*(SCALE_W+1) +: SCALE_W+1];
    assign motor0_ramp_select_o = ramp_mode_control_r[csrm_pkg::MOTOR0_RAMP_LSB +: csrm_pkg::RAMP_SEL_W];
    assign motor1_ramp_select_o = ramp_mode_control_r[csrm_pkg::MOTOR1_RAMP_LSB +: csrm_pkg::RAMP_SEL_W];
    assign motor0_ramp_cmd_o = cmd0_r;
    assign motor1_ramp_cmd_o = cmd1_r;
    assign axis_interp_o = ramp_mode_control_r[csrm_pkg::AXIS_INTERP_BIT];
    assign sync_update_o = sync_on;
endmodule
`default_nettype wire

/* sim/csrm_checker.sv */
// checker for the current scale and ramp mode register bank
// assumes one clock domain; bound to csrm_top and sees only its ports
`timescale 1ns/1ps
`default_nettype none
module csrm_checker #(
    parameter int SCALE_W = 8
) (
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [csrm_pkg::ADDR_W-1:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [3:0] pstrb_i,
    input wire logic [31:0] prdata_o,
    input wire logic pready_o,
    input wire logic pslverr_o,
    input wire logic motor0_target_wr_i,
    input wire logic motor1_target_wr_i,
    input wire logic motor0_target_apply_o,
    input wire logic motor1_target_apply_o,
    input wire logic [SCALE_W:0] motor0_phase_a_scale_o,
    input wire logic [SCALE_W:0] motor0_phase_b_scale_o,
    input wire logic [SCALE_W:0] motor1_phase_c_scale_o,
    input wire logic [SCALE_W:0] motor1_phase_d_scale_o,
    input wire logic [1:0] motor0_ramp_select_o,
    input wire logic [1:0] motor1_ramp_select_o,
    input wire logic [3:0] motor0_ramp_cmd_o,
    input wire logic [3:0] motor1_ramp_cmd_o,
    input wire logic axis_interp_o,
    input wire logic sync_update_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    // zero in a lane stands for the full 256
    function automatic logic [8:0] lane(input logic [31:0] w, input int i);
        return (w[8*i +: 8] == 8'h00) ? 9'h100 : {1'b0, w[8*i +: 8]};
    endfunction
    function automatic logic [1:0] fld(input logic [31:0] w, input int lsb);
        return w[lsb +: 2];
    endfunction
    sequence s_done;
        psel_i && penable_i && pready_o;
    endsequence
    sequence s_scale_wr;
        s_done ##0 (pwrite_i && paddr_i == csrm_pkg::PHASE_SCALE_ADDR && pstrb_i == 4'hF);
    endsequence
    sequence s_ramp_wr;
        s_done ##0 (pwrite_i && paddr_i == csrm_pkg::RAMP_MODE_ADDR && pstrb_i == 4'hF);
    endsequence
    a_ready_one_wait: assert property ($rose(penable_i) && psel_i |=> pready_o) else $error("ready not in second access cycle");
    a_ready_pulse: assert property (pready_o |=> !pready_o) else $error("ready longer than one cycle");
    a_scale_lanes: assert property (s_scale_wr |-> ##2 (
        motor0_phase_a_scale_o == lane($past(pwdata_i, 2), 0) && motor0_phase_b_scale_o == lane($past(pwdata_i, 2), 1)
        && motor1_phase_c_scale_o == lane($past(pwdata_i, 2), 2) && motor1_phase_d_scale_o == lane($past(pwdata_i, 2), 3)))
        else $error("scale outputs differ from written factors");
    a_ramp_select: assert property (s_ramp_wr |-> ##2 (motor0_ramp_select_o == fld($past(pwdata_i, 2), 0)
        && motor1_ramp_select_o == fld($past(pwdata_i, 2), 2))) else $error("ramp select fields wrong");
    a_ramp_cmd_hot: assert property (s_ramp_wr |-> ##2 (motor0_ramp_cmd_o == 4'h1 << motor0_ramp_select_o
        && motor1_ramp_cmd_o == 4'h1 << motor1_ramp_select_o)) else $error("ramp command not decoded");
    a_ramp_flags: assert property (s_ramp_wr |-> ##2
        {axis_interp_o, sync_update_o} == fld($past(pwdata_i, 2), 8)) else $error("ramp option bits wrong");
    a_sync_pair: assert property (sync_update_o && motor1_target_wr_i |=> motor0_target_apply_o && motor1_target_apply_o)
        else $error("joint target apply missing");
    a_sync_defer: assert property (sync_update_o && motor0_target_wr_i && !motor1_target_wr_i |=> !motor0_target_apply_o)
        else $error("motor 0 applied without motor 1 write");
    a_own_apply: assert property (!sync_update_o && motor1_target_wr_i |=> motor1_target_apply_o)
        else $error("independent apply missing");
    a_unused_zero: assert property (s_done ##0 (!pwrite_i && paddr_i == csrm_pkg::RAMP_MODE_ADDR) |->
        (prdata_o & ~csrm_pkg::RAMP_MODE_MASK) == 32'h0000_0000) else $error("unused ramp bits read nonzero");
    a_bad_addr: assert property (s_done ##0 (paddr_i != csrm_pkg::PHASE_SCALE_ADDR && paddr_i != csrm_pkg::RAMP_MODE_ADDR
        && paddr_i != csrm_pkg::BANK_STATUS_ADDR) |-> pslverr_o) else $error("unmapped access not refused");
endmodule
bind csrm_top csrm_checker #(.SCALE_W(SCALE_W)) u_chk (.clk_i(clk_i), .rstn_i(rstn_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(pstrb_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .motor0_target_wr_i(motor0_target_wr_i),
    .motor1_target_wr_i(motor1_target_wr_i), .motor0_target_apply_o(motor0_target_apply_o),
    .motor1_target_apply_o(motor1_target_apply_o), .motor0_phase_a_scale_o(motor0_phase_a_scale_o),
    .motor0_phase_b_scale_o(motor0_phase_b_scale_o), .motor1_phase_c_scale_o(motor1_phase_c_scale_o),
    .motor1_phase_d_scale_o(motor1_phase_d_scale_o), .motor0_ramp_select_o(motor0_ramp_select_o),
    .motor1_ramp_select_o(motor1_ramp_select_o), .motor0_ramp_cmd_o(motor0_ramp_cmd_o),
    .motor1_ramp_cmd_o(motor1_ramp_cmd_o), .axis_interp_o(axis_interp_o), .sync_update_o(sync_update_o));
`default_nettype wire

/* sim/csrm_host.sv */
// host model: apb master that programs the bank
// assumes callers enter xfer just after a rising edge, one edge apart
`timescale 1ns/1ps
`default_nettype none
module csrm_host (
    input wire logic clk_i,
    input wire logic pready_i,
    input wire logic pslverr_i,
    input wire logic [31:0] prdata_i,
    output logic psel_o,
    output logic penable_o,
    output logic pwrite_o,
    output logic [9:0] paddr_o,
    output logic [31:0] pwdata_o,
    output logic [3:0] pstrb_o
);
    initial begin
        psel_o = 1'b0;
        penable_o = 1'b0;
        pwrite_o = 1'b0;
        paddr_o = 10'h000;
        pwdata_o = 32'h0000_0000;
        pstrb_o = 4'h0;
    end
    // request held until ready is seen; no wait count assumed
    task automatic xfer(input logic w, input logic [9:0] a, input logic [31:0] d, input logic [3:0] s,
        output logic [31:0] r, output logic e);
        psel_o <= 1'b1;
        pwrite_o <= w;
        paddr_o <= a;
        pwdata_o <= d;
        pstrb_o <= s;
        @(posedge clk_i);
        penable_o <= 1'b1;
        @(posedge clk_i);
        while (pready_i !== 1'b1) @(posedge clk_i);
        r = prdata_i;
        e = pslverr_i;
        psel_o <= 1'b0;
        penable_o <= 1'b0;
    endtask
endmodule
`default_nettype wire

/* sim/csrm_top_test.sv */
// self-checking bench for the current scale and ramp mode bank
// assumes csrm_host drives apb and the bench pulses target writes
`timescale 1ns/1ps
`default_nettype none
module csrm_top_test;
    typedef struct packed {logic [31:0] sc; logic [31:0] rm; logic [31:0] rd; logic [3:0] c0; logic [3:0] c1;} csrm_row_t;
    // host keeps factors legal and equal per motor, mostly above 128
    localparam csrm_row_t ROWS [4] = '{
        '{32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 4'h1, 4'h1},
        '{32'hFFFF_8181, 32'h0000_0106, 32'h0000_0106, 4'h4, 4'h2},
        '{32'h2020_C0C0, 32'hFFFF_FCF9, 32'h0000_0009, 4'h2, 4'h4},
        '{32'h8181_0000, 32'h0000_020F, 32'h0000_020F, 4'h8, 4'h8}};
    logic clk, rstn, psel, pen, pwr, prdy, perr, m0wr, m1wr, ap0, ap1, ai, su, ev;
    logic [9:0] paddr;
    logic [31:0] pwd, prd, rv;
    logic [3:0] pstrb, c0, c1;
    logic [8:0] sa, sb, sc, sd;
    logic [1:0] s0, s1;
    int n_mismatch = 0, checked = 0, cyc = 0;
    csrm_host host (.clk_i(clk), .pready_i(prdy), .pslverr_i(perr), .prdata_i(prd), .psel_o(psel), .penable_o(pen),
        .pwrite_o(pwr), .paddr_o(paddr), .pwdata_o(pwd), .pstrb_o(pstrb));
    csrm_top uut (.clk_i(clk), .rstn_i(rstn), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr),
        .pwdata_i(pwd), .pstrb_i(pstrb), .prdata_o(prd), .pready_o(prdy), .pslverr_o(perr), .motor0_target_wr_i(m0wr),
        .motor1_target_wr_i(m1wr), .motor0_target_apply_o(ap0), .motor1_target_apply_o(ap1),
        .motor0_phase_a_scale_o(sa), .motor0_phase_b_scale_o(sb), .motor1_phase_c_scale_o(sc),
        .motor1_phase_d_scale_o(sd), .motor0_ramp_select_o(s0), .motor1_ramp_select_o(s1), .motor0_ramp_cmd_o(c0),
        .motor1_ramp_cmd_o(c1), .axis_interp_o(ai), .sync_update_o(su));
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        checked++;
        if (s !== e) begin
            n_mismatch++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    function automatic logic [8:0] m(input logic [7:0] f);
        return (f == 8'h00) ? 9'h100 : {1'b0, f};
    endfunction
    task automatic wr(input logic [9:0] a, input logic [31:0] d, input logic [3:0] s);
        @(posedge clk);
        host.xfer(1'b1, a, d, s, rv, ev);
    endtask
    task automatic rd(input logic [9:0] a);
        @(posedge clk);
        host.xfer(1'b0, a, 32'h0000_0000, 4'hF, rv, ev);
    endtask
    task automatic pulse(input logic [1:0] w);
        @(posedge clk);
        {m1wr, m0wr} <= w;
        @(posedge clk);
        {m1wr, m0wr} <= 2'b00;
        @(posedge clk);
    endtask
    // a hang ends in the same report
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            n_mismatch++;
            test_done();
        end
    end
    initial begin
        rstn = 1'b0;
        {m1wr, m0wr} = 2'b00;
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        repeat (2) @(posedge clk);
        chk({sa, sd, c0, c1}, {9'h100, 9'h100, 4'h1, 4'h1});
        rd(csrm_pkg::PHASE_SCALE_ADDR);
        chk(rv, csrm_pkg::PHASE_SCALE_RST);
        rd(csrm_pkg::RAMP_MODE_ADDR);
        chk(rv, csrm_pkg::RAMP_MODE_RST);
        foreach (ROWS[i]) begin
            wr(csrm_pkg::PHASE_SCALE_ADDR, ROWS[i].sc, 4'hF);
            wr(csrm_pkg::RAMP_MODE_ADDR, ROWS[i].rm, 4'hF);
            repeat (2) @(posedge clk);
            chk({sa, sb}, {m(ROWS[i].sc[7:0]), m(ROWS[i].sc[15:8])});
            chk({sc, sd}, {m(ROWS[i].sc[23:16]), m(ROWS[i].sc[31:24])});
            chk({c0, c1, s0, s1}, {ROWS[i].c0, ROWS[i].c1, ROWS[i].rd[1:0], ROWS[i].rd[3:2]});
            chk({ai, su}, ROWS[i].rd[9:8]);
            rd(csrm_pkg::RAMP_MODE_ADDR);
            chk(rv, ROWS[i].rd);
            rd(csrm_pkg::PHASE_SCALE_ADDR);
            chk(rv, ROWS[i].sc);
        end
        // byte lanes: only the motor 1 factors change
        wr(csrm_pkg::PHASE_SCALE_ADDR, 32'hA0A0_5555, 4'hC);
        repeat (2) @(posedge clk);
        chk({sa, sb, sc, sd}, {9'h100, 9'h100, 9'h0A0, 9'h0A0});
        rd(10'h3FC);
        chk(rv, 32'h0000_0000);
        chk(ev, 1'b1);
        wr(csrm_pkg::BANK_STATUS_ADDR, 32'hFFFF_FFFF, 4'hF);
        chk(ev, 1'b1);
        // joint target update: motor 0 waits for motor 1
        wr(csrm_pkg::RAMP_MODE_ADDR, 32'h0000_0100, 4'hF);
        repeat (2) @(posedge clk);
        pulse(2'b01);
        chk({ap0, ap1}, 2'b00);
        rd(csrm_pkg::BANK_STATUS_ADDR);
        chk(rv, 32'h0000_0001);
        pulse(2'b10);
        chk({ap0, ap1}, 2'b11);
        // a waiting motor 0 target is released once the mode is cleared
        pulse(2'b01);
        chk({ap0, ap1}, 2'b00);
        wr(csrm_pkg::RAMP_MODE_ADDR, 32'h0000_0000, 4'hF);
        repeat (2) @(posedge clk);
        chk({ap0, ap1}, 2'b10);
        pulse(2'b01);
        chk({ap0, ap1}, 2'b10);
        pulse(2'b10);
        chk({ap0, ap1}, 2'b01);
        // reset in mid-run brings the programmed factors back to full scale
        rstn <= 1'b0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        repeat (2) @(posedge clk);
        chk({sc, sd, c0, c1}, {9'h100, 9'h100, 4'h1, 4'h1});
        rd(csrm_pkg::PHASE_SCALE_ADDR);
        chk(rv, csrm_pkg::PHASE_SCALE_RST);
        test_done();
    end
endmodule
`default_nettype wire
